// [design/uem_params.svh]
// Register offsets, field layouts and reset values of the uncorrectable error block
`ifndef UEM_PARAMS_SVH
`define UEM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define UEM_OFF_STATUS   12'h104
`define UEM_OFF_MASK     12'h108
`define UEM_OFF_SEV      12'h10C
`define UEM_OFF_FEP      12'h118
`define UEM_OFF_IRQ_EN   12'h130
`define UEM_OFF_IRQ_ST   12'h134
`define UEM_OFF_IRQ_CLR  12'h138
`define UEM_OFF_MSG      12'h13C

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define UEM_IMPL_BITS    32'h003FF011
`define UEM_MASK_RESET   32'h00000000
`define UEM_SEV_RESET    32'h00062011
`define UEM_FEP_W        5
`define UEM_NCLASS       22

// Interrupt event bit positions
`define UEM_IRQ_FATAL    0
`define UEM_IRQ_NONFATAL 1
`define UEM_IRQ_W        2

`endif

// [design/uem_pkg.sv]
// Types shared by the uncorrectable error mask and severity block
package uem_pkg;

  // ----------------------------------------------------------------------------
  // Error report carried toward the message generator
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       fatal;
    logic [4:0] pos;
  } uem_report_t;

  typedef enum logic [2:0] {
    UEM_IDLE   = 3'b001,
    UEM_ACCESS = 3'b010,
    UEM_DONE   = 3'b100
  } uem_bus_state_t;

endpackage

// [design/uem_pick.sv]
// Finds the lowest reportable error class among the pending events
module uem_pick #(
  parameter int N = 22
) (
  input  wire logic [N-1:0] req,
  output logic              any,
  output logic [4:0]        pos
);

  // ----------------------------------------------------------------------------
  // Priority search
  // ----------------------------------------------------------------------------
  always_comb begin
    any = 1'b0;
    pos = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        pos = 5'(i);
      end
    end
  end

endmodule

// [design/uem_top.sv]
// Uncorrectable error mask, severity and status logic with an APB slave
//
// The APB slave port was chosen for this implementation.
`include "uem_params.svh"

module uem_top #(
  parameter int NCLASS = `UEM_NCLASS
) (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        STICKY_RST_N,
  input  wire logic [31:0] ERR_EVENT,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             HDR_LOG_STB,
  output logic             MSG_FATAL_STB,
  output logic             MSG_NONFATAL_STB,
  output logic [4:0]       MSG_POS,
  output logic             IRQ
);

  // ----------------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------------
  localparam logic [31:0] IMPL = `UEM_IMPL_BITS;

  logic [31:0]           mask_q;
  logic [31:0]           mask_d;
  logic [31:0]           sev_q;
  logic [31:0]           sev_d;
  logic [31:0]           stat_q;
  logic [31:0]           stat_d;
  logic [`UEM_FEP_W-1:0] fep_q;
  logic [`UEM_FEP_W-1:0] fep_d;
  logic                  fep_vld_q;
  logic                  fep_vld_d;
  logic [`UEM_IRQ_W-1:0] irq_en_q;
  logic [`UEM_IRQ_W-1:0] irq_en_d;
  logic [`UEM_IRQ_W-1:0] irq_st_q;
  logic [`UEM_IRQ_W-1:0] irq_st_d;
  logic [31:0]           prdata_q;
  logic [31:0]           prdata_d;
  logic                  pready_q;
  logic                  pready_d;
  logic                  pslverr_q;
  logic                  pslverr_d;
  logic                  irq_q;
  logic                  irq_d;
  uem_pkg::uem_report_t  rep_q;
  uem_pkg::uem_report_t  rep_d;
  logic                  msg_non_q;
  logic                  msg_non_d;
  uem_pkg::uem_bus_state_t bus_q;
  uem_pkg::uem_bus_state_t bus_d;

  logic [31:0]           ev;
  logic [31:0]           reportable;
  logic                  any_rep;
  logic [4:0]            first_pos;
  logic                  wr_acc;
  logic                  rd_acc;
  logic                  hit;

  // ----------------------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------------------
  // Events come from core logic on MCLK, so no synchroniser is needed
  assign ev         = ERR_EVENT & IMPL;
  // A set mask bit removes its class from logging and reporting
  assign reportable = ev & ~mask_q;

  uem_pick #(
    .N (NCLASS)
  ) u_pick (
    .req (reportable[NCLASS-1:0]),
    .any (any_rep),
    .pos (first_pos)
  );

  // ----------------------------------------------------------------------------
  // APB slave sequencing
  // ----------------------------------------------------------------------------
  // One wait state keeps read data registered; answer arrives in second access cycle
  always_comb begin
    bus_d    = bus_q;
    pready_d = 1'b0;
    case (bus_q)
      uem_pkg::UEM_IDLE: begin
        if (PSEL && PENABLE) begin
          bus_d    = uem_pkg::UEM_ACCESS;
          pready_d = 1'b1;
        end
      end
      uem_pkg::UEM_ACCESS: begin
        bus_d = uem_pkg::UEM_DONE;
      end
      uem_pkg::UEM_DONE: begin
        bus_d = uem_pkg::UEM_IDLE;
      end
      default: begin
        bus_d = uem_pkg::UEM_IDLE;
      end
    endcase
  end

  assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_acc = PSEL && PENABLE && !PREADY && (bus_q == uem_pkg::UEM_IDLE) && !PWRITE;
  assign hit    = (PADDR == `UEM_OFF_STATUS) || (PADDR == `UEM_OFF_MASK)
               || (PADDR == `UEM_OFF_SEV)    || (PADDR == `UEM_OFF_FEP)
               || (PADDR == `UEM_OFF_IRQ_EN) || (PADDR == `UEM_OFF_IRQ_ST)
               || (PADDR == `UEM_OFF_IRQ_CLR) || (PADDR == `UEM_OFF_MSG);

  // ----------------------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------------------
  always_comb begin
    mask_d    = mask_q;
    sev_d     = sev_q;
    stat_d    = stat_q | ev;
    fep_d     = fep_q;
    fep_vld_d = fep_vld_q;
    irq_en_d  = irq_en_q;
    irq_st_d  = irq_st_q;
    prdata_d  = prdata_q;
    // Error answer is decided as the access is taken so it stands with ready
    pslverr_d = PSEL && PENABLE && !PREADY && (bus_q == uem_pkg::UEM_IDLE) && PWRITE && !hit;
    if (wr_acc) begin
      case (PADDR)
        `UEM_OFF_MASK: mask_d = PWDATA & IMPL;
        `UEM_OFF_SEV:  sev_d  = PWDATA & IMPL;
        // Set wins over clear so a same-cycle event is kept
        `UEM_OFF_STATUS: stat_d = (stat_q & ~PWDATA) | ev;
        `UEM_OFF_IRQ_EN: irq_en_d = PWDATA[`UEM_IRQ_W-1:0];
        `UEM_OFF_IRQ_CLR: irq_st_d = irq_st_q & ~PWDATA[`UEM_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    if (rd_acc) begin
      case (PADDR)
        `UEM_OFF_STATUS: prdata_d = stat_q;
        `UEM_OFF_MASK:   prdata_d = mask_q;
        `UEM_OFF_SEV:    prdata_d = sev_q;
        `UEM_OFF_FEP:    prdata_d = {27'h0, fep_q};
        `UEM_OFF_IRQ_EN: prdata_d = {30'h0, irq_en_q};
        `UEM_OFF_IRQ_ST: prdata_d = {30'h0, irq_st_q};
        `UEM_OFF_MSG:    prdata_d = {26'h0, fep_vld_q, fep_q};
        default:         prdata_d = 32'h00000000;
      endcase
    end
    // Pointer latches once; cleared only by the sticky reset
    if (any_rep && !fep_vld_q) begin
      fep_d     = first_pos;
      fep_vld_d = 1'b1;
    end
    // Severity decides which interrupt event each reported class raises and which message kind the lowest one raises
    if (|(reportable & sev_q)) begin
      irq_st_d[`UEM_IRQ_FATAL] = 1'b1;
    end
    if (|(reportable & ~sev_q)) begin
      irq_st_d[`UEM_IRQ_NONFATAL] = 1'b1;
    end
    rep_d.valid = any_rep;
    rep_d.fatal = any_rep && sev_q[first_pos];
    rep_d.pos   = first_pos;
    msg_non_d   = any_rep && !sev_q[first_pos];
    irq_d       = |(irq_st_d & irq_en_d);
  end

  // ----------------------------------------------------------------------------
  // Sticky registers
  // ----------------------------------------------------------------------------
  // Survive the ordinary reset; only the sticky reset returns them to default
  always_ff @(posedge MCLK or negedge STICKY_RST_N) begin
    if (!STICKY_RST_N) begin
      mask_q    <= `UEM_MASK_RESET;
      sev_q     <= `UEM_SEV_RESET;
      stat_q    <= 32'h00000000;
      fep_q     <= 5'h00;
      fep_vld_q <= 1'b0;
    end else begin
      mask_q    <= mask_d;
      sev_q     <= sev_d;
      stat_q    <= stat_d;
      fep_q     <= fep_d;
      fep_vld_q <= fep_vld_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Non-sticky registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_q     <= uem_pkg::UEM_IDLE;
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      irq_en_q  <= 2'h0;
      irq_st_q  <= 2'h0;
      irq_q     <= 1'b0;
      rep_q     <= '0;
      msg_non_q <= 1'b0;
    end else begin
      bus_q     <= bus_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      irq_en_q  <= irq_en_d;
      irq_st_q  <= irq_st_d;
      irq_q     <= irq_d;
      rep_q     <= rep_d;
      msg_non_q <= msg_non_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign PRDATA           = prdata_q;
  assign PREADY           = pready_q;
  assign PSLVERR          = pslverr_q;
  assign HDR_LOG_STB      = rep_q.valid;
  assign MSG_FATAL_STB    = rep_q.fatal;
  assign MSG_NONFATAL_STB = msg_non_q;
  assign MSG_POS          = rep_q.pos;
  assign IRQ              = irq_q;

endmodule

// [sim/uem_rc_model.sv]
// Root complex model that counts error messages
module uem_rc_model (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       fat,
  input wire logic       non,
  input wire logic [4:0] pos,
  output int             n_fat,
  output int             n_non,
  output logic [4:0]     last
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_fat <= 0;
      n_non <= 0;
      last <= 5'h00;
    end else if (fat || non) begin
      n_fat <= n_fat + int'(fat);
      n_non <= n_non + int'(non);
      last <= pos;
    end
  end
endmodule

// [sim/uem_props.sv]
// Assertions on the ports of the error block
`include "uem_params.svh"
module uem_props #(
  parameter int NCLASS = 22
) (
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic        STICKY_RST_N,
  input wire logic [31:0] ERR_EVENT,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        HDR_LOG_STB,
  input wire logic        MSG_FATAL_STB,
  input wire logic        MSG_NONFATAL_STB,
  input wire logic [4:0]  MSG_POS,
  input wire logic        IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mask_q, sev_q, rep_q, sevp_q;
  logic [2:0]  act_q;
  logic [4:0]  low;
  logic        wr, mapped;
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  assign mapped = PADDR inside {12'h104, 12'h108, 12'h10C, 12'h118, 12'h130, 12'h134,
                                12'h138, 12'h13C};
  always_comb begin
    low = 5'h00;
    for (int i = 31; i >= 0; i--) if (rep_q[i]) low = i[4:0];
  end
  // Software copy of mask and severity, kept from observed writes
  always_ff @(posedge MCLK or negedge STICKY_RST_N) begin
    if (!STICKY_RST_N) begin
      mask_q <= 32'h0;
      sev_q <= `UEM_SEV_RESET;
    end else if (wr && PADDR == 12'h108) mask_q <= PWDATA & `UEM_IMPL_BITS;
    else if (wr && PADDR == 12'h10C) sev_q <= PWDATA & `UEM_IMPL_BITS;
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rep_q <= 32'h0;
      sevp_q <= 32'h0;
      act_q <= 3'h0;
    end else begin
      rep_q <= ERR_EVENT & `UEM_IMPL_BITS & ~mask_q;
      sevp_q <= sev_q;
      act_q <= {act_q[1:0], MSG_FATAL_STB | MSG_NONFATAL_STB | wr};
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N || !STICKY_RST_N);
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  chk_ready_access: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  chk_err_unmapped: assert property (PSLVERR |-> PREADY && PWRITE && !mapped)
    else $error("bad error reply");
  chk_rdata_hold: assert property ($changed(PRDATA) |-> PREADY && !PWRITE)
    else $error("read data moved");
  chk_log_cause: assert property (HDR_LOG_STB == (rep_q != 32'h0))
    else $error("log strobe wrong");
  chk_msg_pos: assert property (HDR_LOG_STB |-> MSG_POS == low)
    else $error("message position wrong");
  chk_msg_sev: assert property (HDR_LOG_STB |-> MSG_FATAL_STB == sevp_q[MSG_POS]
    && MSG_NONFATAL_STB != sevp_q[MSG_POS]) else $error("message severity wrong");
  chk_msg_idle: assert property (!HDR_LOG_STB |-> !(MSG_FATAL_STB || MSG_NONFATAL_STB))
    else $error("message without log");
  chk_irq_cause: assert property ($rose(IRQ) |-> act_q != 3'h0 || MSG_FATAL_STB || MSG_NONFATAL_STB)
    else $error("interrupt without cause");
endmodule
bind uem_top uem_props #(.NCLASS(NCLASS)) u_props (.MCLK(MCLK), .RST_N(RST_N),
  .STICKY_RST_N(STICKY_RST_N), .ERR_EVENT(ERR_EVENT), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .HDR_LOG_STB(HDR_LOG_STB), .MSG_FATAL_STB(MSG_FATAL_STB),
  .MSG_NONFATAL_STB(MSG_NONFATAL_STB), .MSG_POS(MSG_POS), .IRQ(IRQ));

// [sim/tb.sv]
// Self-checking bench for the error mask and severity block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] IMPL = 32'h003FF011;
  logic        mclk, rst_n = 1'b0, srst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        prdy, perr, err, fat, non, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] ev = 32'h0, pwdata = 32'h0, prdata, rd, r;
  logic [4:0]  pos, last;
  int          miscompares, total_checks, n_fat, n_non, cyc, ef, en, c;
  int          cls[12] = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};
  uem_top uut (.MCLK(mclk), .RST_N(rst_n), .STICKY_RST_N(srst_n), .ERR_EVENT(ev),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr), .HDR_LOG_STB(),
    .MSG_FATAL_STB(fat), .MSG_NONFATAL_STB(non), .MSG_POS(pos), .IRQ(irq));
  uem_rc_model rc (.clk(mclk), .rst_n(rst_n), .fat(fat), .non(non), .pos(pos),
    .n_fat(n_fat), .n_non(n_non), .last(last));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Request held until the edge that samples ready
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    do @(posedge mclk); while (prdy !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rchk(string nm, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  // One-cycle event, then room for the model to count it
  task automatic fire(logic [31:0] e);
    @(posedge mclk);
    ev <= e;
    @(posedge mclk);
    ev <= 32'h0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    void'($urandom(64157));
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    srst_n <= 1'b1;
    rchk("mask reset", 12'h108, 32'h0);
    rchk("sev reset", 12'h10C, 32'h00062011);
    c = cls[$urandom_range(11)];
    fire(32'h1 << c);
    rchk("pointer", 12'h118, 32'(c));
    rchk("status set", 12'h104, 32'h1 << c);
    apb(1'b1, 12'h104, 32'h1 << c);
    rchk("status clear", 12'h104, 32'h0);
    $display("reset and status test done");
    r = $urandom();
    apb(1'b1, 12'h10C, r);
    rchk("sev rw", 12'h10C, r & IMPL);
    apb(1'b1, 12'h108, 32'hFFFFFFFF);
    rchk("mask rw", 12'h108, IMPL);
    ef = int'((32'h00062011 >> c) & 32'h1);
    en = 1 - ef;
    foreach (cls[i]) begin
      apb(1'b1, 12'h108, IMPL & ~(32'h1 << cls[i]));
      fire(32'hFFFFFFFF);
      ef += int'(r[cls[i]]);
      en += int'(!r[cls[i]]);
      apb(1'b1, 12'h108, 32'h1 << cls[i]);
      fire(32'h1 << cls[i]);
      chk("fatal msgs", 32'(n_fat), 32'(ef));
      chk("nonfatal msgs", 32'(n_non), 32'(en));
      chk("msg pos", 32'(last), 32'(cls[i]));
    end
    $display("mask and severity test done");
    apb(1'b1, 12'h108, 32'h0);
    apb(1'b1, 12'h138, 32'h3);
    apb(1'b1, 12'h130, 32'h1);
    apb(1'b1, 12'h10C, IMPL);
    fire(32'h1 << c);
    chk("irq raised", 32'(irq), 32'h1);
    apb(1'b1, 12'h138, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq cleared", 32'(irq), 32'h0);
    apb(1'b1, 12'h10C, 32'h0);
    fire(32'h1 << c);
    chk("irq masked", 32'(irq), 32'h0);
    rchk("irq status", 12'h134, 32'h2);
    apb(1'b1, 12'h108, 32'h00100000);
    // Ordinary reset alone must leave the sticky registers untouched
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rchk("mask sticky", 12'h108, 32'h00100000);
    rchk("sev sticky", 12'h10C, 32'h0);
    rchk("pointer sticky", 12'h13C, 32'h20 | 32'(c));
    rchk("irq status reset", 12'h134, 32'h0);
    rchk("clear reads 0", 12'h138, 32'h0);
    apb(1'b1, 12'h200, 32'h5A);
    chk("unmapped err", 32'(err), 32'h1);
    rchk("unmapped read", 12'h200, 32'h0);
    $display("interrupt and bus test done");
    test_done();
  end
endmodule
